// ---- inc/mbam_pkg.sv ----
// package: constants, types and range tables for the slave address map
package mbam_pkg;

   typedef enum logic [1:0] {
      KIND_COIL = 2'h0,
      KIND_INPUT = 2'h1,
      KIND_INREG = 2'h2,
      KIND_HOLD = 2'h3
   } mbam_kind_e;

   typedef enum logic [1:0] {
      MODE_TYPED = 2'h0,
      MODE_SHORT = 2'h1,
      MODE_EXTENDED = 2'h2
   } mbam_mode_e;

   typedef enum logic [3:0] {
      RG_INPUT_POINT = 4'h0,
      RG_SPECIAL_RELAY_POINT = 4'h1,
      RG_OUTPUT_POINT = 4'h2,
      RG_INTERNAL_RELAY_POINT = 4'h3,
      RG_STAGE_BIT = 4'h4,
      RG_TIMER_BIT = 4'h5,
      RG_COUNTER_CONTACT_BIT = 4'h6,
      RG_TIMER_VALUE = 4'h7,
      RG_COUNTER_VALUE = 4'h8,
      RG_USER_LOW = 4'h9,
      RG_NONVOL = 4'hA,
      RG_USER_HIGH = 4'hB
   } mbam_space_e;

   localparam int N_SPACE = 12;

   // function codes
   localparam logic [7:0] FC_READ_COILS = 8'h01;
   localparam logic [7:0] FC_READ_INPUTS = 8'h02;
   localparam logic [7:0] FC_READ_HOLDING = 8'h03;
   localparam logic [7:0] FC_READ_INREGS = 8'h04;
   localparam logic [7:0] FC_WRITE_COIL = 8'h05;
   localparam logic [7:0] FC_WRITE_REG = 8'h06;
   localparam logic [7:0] FC_WRITE_COILS = 8'h0F;
   localparam logic [7:0] FC_WRITE_REGS = 8'h10;

   // exception codes
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
   localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
   localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

   // range table, one entry per space in enum order
   localparam logic [16:0] RANGE_LO [N_SPACE] = '{
      17'h0_0800, 17'h0_0C00, 17'h0_0800, 17'h0_0C00, 17'h0_1400, 17'h0_1800,
      17'h0_1900, 17'h0_0000, 17'h0_0200, 17'h0_0280, 17'h0_0F00, 17'h0_1000};
   localparam logic [16:0] RANGE_HI [N_SPACE] = '{
      17'h0_09FF, 17'h0_0DFF, 17'h0_09FF, 17'h0_0FFF, 17'h0_17FF, 17'h0_18FF,
      17'h0_197F, 17'h0_00FF, 17'h0_027F, 17'h0_0EFF, 17'h0_0F7F, 17'h0_1FFF};
   localparam mbam_kind_e RANGE_KIND [N_SPACE] = '{
      KIND_INPUT, KIND_INPUT, KIND_COIL, KIND_COIL, KIND_COIL, KIND_COIL,
      KIND_COIL, KIND_INREG, KIND_INREG, KIND_HOLD, KIND_HOLD, KIND_HOLD};
   // discrete spaces index from their range start, word spaces do not
   localparam logic [N_SPACE-1:0] RANGE_DISCRETE = 12'h07F;

   // address-only offsets and window limits, indexed by kind
   localparam logic [16:0] OFS_SHORT [4] = '{17'h0_0001, 17'h0_03E9, 17'h0_0BB9, 17'h0_0FA1};
   localparam logic [16:0] LIM_SHORT [4] = '{17'h0_03E8, 17'h0_0BB8, 17'h0_0FA0, 17'h1_FFFF};
   localparam logic [16:0] OFS_EXT [4] = '{17'h0_0001, 17'h1_86A1, 17'h0_7531, 17'h0_9C41};
   localparam logic [16:0] LIM_EXT [4] = '{17'h0_2710, 17'h1_FFFF, 17'h0_9C40, 17'h1_869F};

   typedef struct packed {
      logic [7:0] func;
      mbam_mode_e mode;
      logic [16:0] addr;
      logic [10:0] count;
   } mbam_req_s;

   typedef struct packed {
      mbam_space_e space;
      logic [12:0] index;
      logic write;
      logic last;
   } mbam_acc_s;

   typedef struct packed {
      logic hit;
      mbam_space_e space;
      logic [12:0] index;
   } mbam_hit_s;

endpackage

// ---- src/mbam_top.sv ----
// slave address map: turns function code plus address into memory accesses
// Summary of operation
// R01 - code 16 writes each supplied word to consecutive word locations
// R02 - inputs at 2048-2559 and special relays at 3072-3583, input type
// R03 - coils decode by range: outputs, relays, stages, timer and counter bits
// R04 - timer current values 0-255 readable as input registers
// R05 - counter current values 512-639 readable as input registers
// R06 - user words as holding registers 640-3839 and 4096-8191
// R07 - non-volatile words as holding registers 3840-3967
// R08 - discrete types subtract range start, word types index directly
// R09 - short convention offsets 1001, 1, 3001, 4001 removed before decode
// R10 - extended convention offsets 100001, 1, 30001, 40001 removed before decode
// R11 - host should prefer the extended convention
// R12 - host gives either type plus address or an offset-coded address
// R13 - supports codes 01, 02, 03, 04, 05, 06, 15, 16
// R14 - host uses RTU framing and supplies function and address
// R15 - out-of-range requests answer illegal address and touch nothing
`timescale 1ns/1ps
module mbam_top (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input mbam_pkg::mbam_req_s REQ,
   output logic ACC_VALID,
   output mbam_pkg::mbam_acc_s ACC,
   output logic EXC_VALID,
   output logic [7:0] EXC_CODE
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } mbam_state_e;

   function automatic mbam_pkg::mbam_hit_s find_space(mbam_pkg::mbam_kind_e kind,
                                                     logic [16:0] a);
      mbam_pkg::mbam_hit_s h;
      logic [16:0] rel;
      h = '{hit: 1'b0, space: mbam_pkg::RG_INPUT_POINT, index: 13'h0000};
      rel = 17'h0_0000;
      for (int i = 0; i < mbam_pkg::N_SPACE; i++) begin
         if (mbam_pkg::RANGE_KIND[i] == kind && a >= mbam_pkg::RANGE_LO[i] &&
             a <= mbam_pkg::RANGE_HI[i]) begin
            h.hit = 1'b1;
            h.space = mbam_pkg::mbam_space_e'(4'(i));
            rel = mbam_pkg::RANGE_DISCRETE[i] ? a - mbam_pkg::RANGE_LO[i] : a; // R08
            h.index = rel[12:0];
         end
      end
      return h;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // request decode

   mbam_pkg::mbam_kind_e kind;
   logic fc_ok;
   logic is_write;
   logic [10:0] n;
   logic win_ok;
   logic [16:0] a;
   logic [16:0] a_end;
   mbam_pkg::mbam_hit_s first;
   mbam_pkg::mbam_hit_s final_hit;
   logic [7:0] err;

   always_comb begin
      kind = mbam_pkg::KIND_COIL;
      fc_ok = 1'b1;
      is_write = 1'b0;
      n = REQ.count;
      unique case (REQ.func) // R13
         mbam_pkg::FC_READ_COILS: kind = mbam_pkg::KIND_COIL;
         mbam_pkg::FC_READ_INPUTS: kind = mbam_pkg::KIND_INPUT; // R02
         mbam_pkg::FC_READ_HOLDING: kind = mbam_pkg::KIND_HOLD;
         mbam_pkg::FC_READ_INREGS: kind = mbam_pkg::KIND_INREG;
         mbam_pkg::FC_WRITE_COIL: begin
            is_write = 1'b1;
            n = 11'h001;
         end
         mbam_pkg::FC_WRITE_REG: begin
            kind = mbam_pkg::KIND_HOLD;
            is_write = 1'b1;
            n = 11'h001;
         end
         mbam_pkg::FC_WRITE_COILS: is_write = 1'b1;
         mbam_pkg::FC_WRITE_REGS: begin
            kind = mbam_pkg::KIND_HOLD; // R01
            is_write = 1'b1;
         end
         default: fc_ok = 1'b0;
      endcase
      // strip the convention offset; the window check confirms the address suits the function's type
      unique case (REQ.mode)
         mbam_pkg::MODE_SHORT: begin
            win_ok = REQ.addr >= mbam_pkg::OFS_SHORT[kind] &&
                     REQ.addr <= mbam_pkg::LIM_SHORT[kind]; // R09
            a = REQ.addr - mbam_pkg::OFS_SHORT[kind]; // R09
         end
         mbam_pkg::MODE_EXTENDED: begin
            win_ok = REQ.addr >= mbam_pkg::OFS_EXT[kind] &&
                     REQ.addr <= mbam_pkg::LIM_EXT[kind]; // R10
            a = REQ.addr - mbam_pkg::OFS_EXT[kind]; // R10
         end
         default: begin
            win_ok = (REQ.mode == mbam_pkg::MODE_TYPED);
            a = REQ.addr;
         end
      endcase
      a_end = a + {6'h00, n} - 17'h0_0001;
      first = find_space(kind, a); // R02 R03 R04 R05 R06 R07
      final_hit = find_space(kind, a_end);
      // a span that leaves its region is refused whole
      if (!fc_ok) begin
         err = mbam_pkg::EXC_ILLEGAL_FUNCTION;
      end else if (n == 11'h000) begin
         err = mbam_pkg::EXC_ILLEGAL_VALUE;
      end else if (!win_ok || !first.hit || !final_hit.hit ||
                   first.space != final_hit.space) begin
         err = mbam_pkg::EXC_ILLEGAL_ADDRESS; // R15
      end else begin
         err = mbam_pkg::EXC_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // access sequencer

   mbam_state_e state;
   mbam_state_e next_state;
   logic [10:0] remaining;
   logic [10:0] next_remaining;
   mbam_pkg::mbam_acc_s next_acc;
   logic next_exc_valid;
   logic [7:0] next_exc_code;
   logic take;

   assign REQ_READY = (state == ST_IDLE);
   assign ACC_VALID = (state == ST_RUN);
   assign take = REQ_VALID && REQ_READY;

   always_comb begin
      next_state = state;
      next_remaining = remaining;
      next_acc = ACC;
      next_exc_valid = 1'b0;
      next_exc_code = EXC_CODE;
      unique case (state)
         ST_IDLE: begin
            if (take && err != mbam_pkg::EXC_NONE) begin
               next_exc_valid = 1'b1; // R15
               next_exc_code = err;
            end else if (take) begin
               next_state = ST_RUN;
               next_remaining = n;
               next_acc.space = first.space;
               next_acc.index = first.index;
               next_acc.write = is_write;
               next_acc.last = (n == 11'h001);
            end
         end
         ST_RUN: begin
            if (ACC.last) begin
               next_state = ST_IDLE;
               next_acc.write = 1'b0;
            end else begin
               next_remaining = remaining - 11'h001;
               next_acc.index = ACC.index + 13'h0001; // R01
               next_acc.last = (remaining == 11'h002);
            end
         end
      endcase
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         state <= ST_IDLE;
         remaining <= 11'h000;
         ACC <= '{space: mbam_pkg::RG_INPUT_POINT, index: 13'h0000, write: 1'b0, last: 1'b0};
         EXC_VALID <= 1'b0;
         EXC_CODE <= mbam_pkg::EXC_NONE;
      end else begin
         state <= next_state;
         remaining <= next_remaining;
         ACC <= next_acc;
         EXC_VALID <= next_exc_valid;
         EXC_CODE <= next_exc_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_multi_write;
      @(posedge MCLK) disable iff (!RSTN)
      take && REQ.func == mbam_pkg::FC_WRITE_REGS && err == mbam_pkg::EXC_NONE
         |=> ACC_VALID && ACC.write && ACC.index == $past(first.index);
   endproperty
   a_multi_write: assert property (p_multi_write) else $error("word write did not start"); // R01

   property p_consecutive;
      @(posedge MCLK) disable iff (!RSTN)
      ACC_VALID && !ACC.last |=> ACC_VALID && ACC.index == $past(ACC.index) + 13'h0001;
   endproperty
   a_consecutive: assert property (p_consecutive) else $error("index not consecutive"); // R01

   property p_special_relay;
      @(posedge MCLK) disable iff (!RSTN)
      take && REQ.func == mbam_pkg::FC_READ_INPUTS && REQ.mode == mbam_pkg::MODE_TYPED &&
         REQ.addr == 17'h0_0C00 && REQ.count == 11'h001
         |=> ACC.space == mbam_pkg::RG_SPECIAL_RELAY_POINT && ACC.index == 13'h0000;
   endproperty
   a_special_relay: assert property (p_special_relay) else $error("relay map wrong"); // R02

   property p_counter_contact;
      @(posedge MCLK) disable iff (!RSTN)
      take && REQ.func == mbam_pkg::FC_READ_COILS && REQ.mode == mbam_pkg::MODE_TYPED &&
         REQ.addr == 17'h0_1900 && REQ.count == 11'h001
         |=> ACC.space == mbam_pkg::RG_COUNTER_CONTACT_BIT && ACC.index == 13'h0000;
   endproperty
   a_counter_contact: assert property (p_counter_contact) else $error("contact map wrong"); // R03

   property p_timer_value;
      @(posedge MCLK) disable iff (!RSTN)
      take && REQ.func == mbam_pkg::FC_READ_INREGS && REQ.mode == mbam_pkg::MODE_TYPED &&
         REQ.addr == 17'h0_0008 && REQ.count == 11'h001
         |=> ACC.space == mbam_pkg::RG_TIMER_VALUE && ACC.index == 13'h0008;
   endproperty
   a_timer_value: assert property (p_timer_value) else $error("timer value map wrong"); // R04

   property p_user_high;
      @(posedge MCLK) disable iff (!RSTN)
      take && REQ.func == mbam_pkg::FC_READ_HOLDING && REQ.mode == mbam_pkg::MODE_TYPED &&
         REQ.addr == 17'h0_1000 && REQ.count == 11'h001
         |=> ACC.space == mbam_pkg::RG_USER_HIGH && ACC.index == 13'h1000;
   endproperty
   a_user_high: assert property (p_user_high) else $error("upper user map wrong"); // R06

   property p_short_hold;
      @(posedge MCLK) disable iff (!RSTN)
      take && REQ.func == mbam_pkg::FC_READ_HOLDING && REQ.mode == mbam_pkg::MODE_SHORT &&
         REQ.addr == 17'h0_13E1 && REQ.count == 11'h001
         |=> ACC.space == mbam_pkg::RG_USER_LOW && ACC.index == 13'h0440;
   endproperty
   a_short_hold: assert property (p_short_hold) else $error("short offset wrong"); // R09

   property p_ext_input;
      @(posedge MCLK) disable iff (!RSTN)
      take && REQ.func == mbam_pkg::FC_READ_INPUTS && REQ.mode == mbam_pkg::MODE_EXTENDED &&
         REQ.addr == 17'h1_8EA1 && REQ.count == 11'h001
         |=> ACC.space == mbam_pkg::RG_INPUT_POINT && ACC.index == 13'h0000;
   endproperty
   a_ext_input: assert property (p_ext_input) else $error("extended offset wrong"); // R10

   property p_reject;
      @(posedge MCLK) disable iff (!RSTN)
      take && err != mbam_pkg::EXC_NONE
         |=> EXC_VALID && EXC_CODE == $past(err) && !ACC_VALID
         ##1 EXC_VALID == $past(take && err != mbam_pkg::EXC_NONE);
   endproperty
   a_reject: assert property (p_reject) else $error("bad request not refused"); // R15

   property p_bad_function;
      @(posedge MCLK) disable iff (!RSTN)
      take && REQ.func == 8'h07 |=> EXC_CODE == mbam_pkg::EXC_ILLEGAL_FUNCTION;
   endproperty
   a_bad_function: assert property (p_bad_function) else $error("unknown code accepted"); // R13

endmodule

// ---- tb/mbam_host.sv ----
// host-side model: presents one request at a time and holds it until taken
`timescale 1ns/1ps
module mbam_host (
   input wire logic MCLK,
   input wire logic REQ_READY,
   output logic REQ_VALID,
   output mbam_pkg::mbam_req_s REQ
);
   initial begin
      REQ_VALID = 1'b0;
      REQ = '0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // either type plus address or an offset-coded address, always with a code
   task automatic send(input mbam_pkg::mbam_req_s r);
      @(posedge MCLK);
      REQ_VALID <= 1'b1;
      REQ <= r;
      @(posedge MCLK);
      while (REQ_READY !== 1'b1) @(posedge MCLK);
      REQ_VALID <= 1'b0;
      // stale request must not look valid after release
      REQ <= ~r;
   endtask
endmodule

// ---- tb/mbam_top_test.sv ----
// self-checking bench for the slave address map
`timescale 1ns/1ps
module mbam_top_test;
   logic mclk;
   logic rstn;
   logic req_valid;
   logic req_ready;
   mbam_pkg::mbam_req_s req;
   logic acc_valid;
   mbam_pkg::mbam_acc_s acc;
   logic exc_valid;
   logic [7:0] exc_code;
   logic [27:0] notes[$];
   logic [27:0] note;
   int mismatches;
   int n_tests;
   int cycles;
   int seed;
   int lo[12] = '{2048, 3072, 2048, 3072, 5120, 6144, 6400, 0, 512, 640, 3840, 4096};
   int hi[12] = '{2559, 3583, 2559, 4095, 6143, 6399, 6527, 255, 639, 3839, 3967, 8191};
   int kd[12] = '{1, 1, 0, 0, 0, 0, 0, 2, 2, 3, 3, 3};

   mbam_top dut (.MCLK(mclk), .RSTN(rstn), .REQ_VALID(req_valid), .REQ_READY(req_ready),
      .REQ(req), .ACC_VALID(acc_valid), .ACC(acc), .EXC_VALID(exc_valid), .EXC_CODE(exc_code));
   mbam_host host (.MCLK(mclk), .REQ_READY(req_ready), .REQ_VALID(req_valid), .REQ(req));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [27:0] got, input logic [27:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // notes the expected accesses or refusal, then hands the request to the host
   task automatic run(input logic [7:0] f, input int mode, input int a, input int n);
      int kind;
      int ofs;
      int wlo;
      int whi;
      int raw;
      int spc;
      logic [7:0] code;
      logic wr;
      mbam_pkg::mbam_req_s r;
      r.func = f;
      r.mode = mbam_pkg::mbam_mode_e'(mode);
      r.addr = 17'(a);
      r.count = 11'(n);
      spc = -1;
      code = 8'h00;
      kind = 0;
      wr = f inside {8'h05, 8'h06, 8'h0F, 8'h10};
      case (f)
         8'h01, 8'h05, 8'h0F: kind = 0;
         8'h02: kind = 1;
         8'h04: kind = 2;
         8'h03, 8'h06, 8'h10: kind = 3;
         default: code = 8'h01;
      endcase
      if (f inside {8'h05, 8'h06}) n = 1;
      ofs = 0;
      wlo = 0;
      whi = 131071;
      if (mode == 1) begin
         ofs = kind == 0 ? 1 : kind == 1 ? 1001 : kind == 2 ? 3001 : 4001;
         whi = kind == 0 ? 1000 : kind == 1 ? 3000 : kind == 2 ? 4000 : 131071;
      end else if (mode == 2) begin
         ofs = kind == 0 ? 1 : kind == 1 ? 100001 : kind == 2 ? 30001 : 40001;
         whi = kind == 0 ? 10000 : kind == 1 ? 131071 : kind == 2 ? 40000 : 99999;
      end
      if (mode != 0) wlo = ofs;
      raw = a - ofs;
      for (int i = 0; i < 12; i++)
         if (kd[i] == kind && raw >= lo[i] && raw + n - 1 <= hi[i]) spc = i;
      if (code == 0 && n == 0) code = 8'h03;
      else if (code == 0 && (a < wlo || a > whi || spc < 0)) code = 8'h02;
      if (code != 0) notes.push_back({1'b1, code, 19'h0});
      else for (int i = 0; i < n; i++)
         notes.push_back({1'b0, 8'h00, 4'(spc), 13'(raw - (spc < 7 ? lo[spc] : 0) + i), wr,
            1'(i == n - 1)});
      host.send(r);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      if (rstn === 1'b1 && (acc_valid === 1'b1 || exc_valid === 1'b1)) begin
         // an unexpected result meets an unknown note and fails
         note = 'x;
         if (notes.size() > 0) note = notes.pop_front();
         if (exc_valid === 1'b1) begin
            check({1'b1, exc_code, 19'h0}, note);
            check(28'(req_ready), 28'h000_0001);
         end else begin
            check({1'b0, 8'h00, acc}, note);
            check(28'(req_ready), 28'h000_0000);
         end
      end
   end

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         conclude();
      end
   end

   initial begin
      seed = 96;
      mismatches = 0;
      n_tests = 0;
      cycles = 0;
      rstn = 1'b0;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      run(8'h10, 0, 1088, 2);
      run(8'h02, 0, 2048, 1); run(8'h02, 0, 3583, 1);
      run(8'h01, 0, 2559, 1); run(8'h01, 0, 3072, 3);
      run(8'h01, 0, 4095, 1); run(8'h01, 0, 5120, 1);
      run(8'h0F, 0, 6398, 2); run(8'h01, 0, 6527, 1);
      run(8'h05, 0, 2064, 0);
      run(8'h04, 0, 8, 1); run(8'h04, 0, 255, 1);
      run(8'h04, 0, 512, 2); run(8'h04, 0, 639, 1);
      run(8'h03, 0, 640, 1); run(8'h03, 0, 3839, 1);
      run(8'h06, 0, 4096, 1); run(8'h03, 0, 8191, 1);
      run(8'h03, 0, 3840, 3); run(8'h03, 0, 3967, 1);
      run(8'h04, 1, 3009, 1); run(8'h01, 1, 3117, 1);
      run(8'h03, 1, 5089, 1); run(8'h02, 1, 3049, 1);
      run(8'h03, 2, 41089, 1); run(8'h01, 2, 2065, 1);
      run(8'h02, 2, 103073, 1); run(8'h04, 2, 30521, 1);
      run(8'h03, 0, 4000, 1); run(8'h01, 0, 4500, 1);
      run(8'h07, 0, 0, 1); run(8'h03, 0, 640, 0);
      run(8'h04, 0, 255, 2); run(8'h03, 0, 3839, 2);
      run(8'h04, 2, 29999, 1); run(8'h03, 0, 8192, 1);
      run(8'h02, 0, 3072, 1); run(8'h01, 0, 6400, 1);
      run(8'h03, 0, 4096, 1); run(8'h02, 2, 102049, 1);
      for (int i = 0; i < 24; i++)
         run(i % 2 ? 8'h10 : 8'h03, 0, 640 + $unsigned($random(seed)) % 3200,
            1 + $unsigned($random(seed)) % 4);
      for (int i = 0; i < 100 && notes.size() > 0; i++) @(posedge mclk);
      repeat (3) @(posedge mclk);
      check(28'(notes.size()), 28'h000_0000);
      check(28'(req_ready), 28'h000_0001);
      conclude();
   end
endmodule
